// *** rtl/parallel_port_pin_mux.sv ***
// Summary of operation
// - Mode-select high: device drives 18-bit address bus for external memory.
// - External memory mode: data pins driven on writes, sampled on reads.
// - Host-port mode: data pins carry 16-bit host transfers to internal memory.
// - Enabled keepers hold undriven data pins at last driven level.
// - Keepers disabled after reset; software enable bit controls them.
// - Float-control low tri-states all address and data pins in any mode.
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_defs.svh"
module parallel_port_pin_mux #(
    parameter int ADDR_W = `ADDR_WIDTH,
    parameter int DATA_W = `DATA_WIDTH
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic port_function_select,
    input wire logic float_n,
    input wire logic bus_keeper_enable,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [DATA_W-1:0] mem_wdata,
    input wire logic mem_write,
    output logic [DATA_W-1:0] mem_rdata,
    input wire logic [DATA_W-1:0] host_rdata,
    input wire logic host_read,
    output logic [ADDR_W-1:0] host_addr,
    output logic [DATA_W-1:0] host_wdata,
    input wire logic [ADDR_W-1:0] port_address_bus_in,
    output logic [ADDR_W-1:0] port_address_bus_out,
    output logic port_address_bus_oe,
    input wire logic [DATA_W-1:0] port_data_bus_in,
    output logic [DATA_W-1:0] port_data_bus_out,
    output logic [DATA_W-1:0] port_data_bus_oe,
    output logic external_memory_mode,
    output logic host_port_mode
);
    // Elaboration-time check: the pin map serves only these widths
    if (ADDR_W != `ADDR_WIDTH || DATA_W != `DATA_WIDTH)
    begin : g_bad_width
        $error("Unsupported bus width");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode state
    pin_mux_pkg::mux_state_e state_reg;
    pin_mux_pkg::mux_state_e state_next;
    logic keeper_en_reg;
    logic keeper_en_next;

    always_comb
    begin
        keeper_en_next = bus_keeper_enable;
        if (!float_n)
        begin
            state_next = pin_mux_pkg::ST_FLOAT;
        end
        else if (port_function_select)
        begin
            state_next = pin_mux_pkg::ST_EXT_MEM;
        end
        else
        begin
            state_next = pin_mux_pkg::ST_HOST;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state_reg <= pin_mux_pkg::ST_FLOAT;
            keeper_en_reg <= `KEEPER_EN_RESET;
        end
        else
        begin
            state_reg <= state_next;
            keeper_en_reg <= keeper_en_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive
    logic [ADDR_W-1:0] aout_next;
    logic aoe_next;
    logic [DATA_W-1:0] dout_next;
    logic [DATA_W-1:0] doe_next;
    logic [DATA_W-1:0] mem_rdata_next;
    logic [ADDR_W-1:0] host_addr_next;
    logic [DATA_W-1:0] host_wdata_next;
    logic ext_next;
    logic hpm_next;
    logic drv_next;
    logic [DATA_W-1:0] dpin_next;

    data_pin_if #(.WIDTH(DATA_W)) dp ();

    bus_keeper #(.WIDTH(DATA_W)) u_keeper (
        .core_clk(core_clk),
        .rst(rst),
        .dp(dp.keeper)
    );

    always_comb
    begin
        aout_next = '0;
        aoe_next = 1'b0;
        drv_next = 1'b0;
        dout_next = '0;
        mem_rdata_next = mem_rdata;
        host_addr_next = host_addr;
        host_wdata_next = host_wdata;
        ext_next = 1'b0;
        hpm_next = 1'b0;
        unique case (state_next)
            pin_mux_pkg::ST_FLOAT:
            begin
                aoe_next = 1'b0;
            end
            pin_mux_pkg::ST_EXT_MEM:
            begin
                ext_next = 1'b1;
                aout_next = mem_addr;
                aoe_next = 1'b1;
                drv_next = mem_write;
                dout_next = mem_wdata;
                if (!mem_write)
                begin
                    mem_rdata_next = port_data_bus_in;
                end
            end
            pin_mux_pkg::ST_HOST:
            begin
                hpm_next = 1'b1;
                aoe_next = 1'b0;
                host_addr_next = port_address_bus_in;
                drv_next = host_read;
                dout_next = host_rdata;
                if (!host_read)
                begin
                    host_wdata_next = port_data_bus_in;
                end
            end
        endcase
    end

    assign dp.drive_en = drv_next;
    assign dp.drive_val = dout_next;
    assign dp.keeper_en = keeper_en_reg & float_n;
    assign dp.pin_in = port_data_bus_in;

    always_comb
    begin
        doe_next = drv_next ? '1 : dp.keep_oe;
        dpin_next = drv_next ? dout_next : dp.keep_val;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            port_address_bus_out <= '0;
            port_address_bus_oe <= 1'b0;
            port_data_bus_out <= '0;
            port_data_bus_oe <= '0;
            mem_rdata <= '0;
            host_addr <= '0;
            host_wdata <= '0;
            external_memory_mode <= 1'b0;
            host_port_mode <= 1'b0;
        end
        else
        begin
            port_address_bus_out <= aout_next;
            port_address_bus_oe <= aoe_next;
            port_data_bus_out <= dpin_next;
            port_data_bus_oe <= doe_next;
            mem_rdata <= mem_rdata_next;
            host_addr <= host_addr_next;
            host_wdata <= host_wdata_next;
            external_memory_mode <= ext_next;
            host_port_mode <= hpm_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence float_seen;
        !float_n;
    endsequence

    float_addr_a: assert property (@(posedge core_clk) disable iff (rst)
        float_seen |=> !port_address_bus_oe) else $error("Address driven while floated");
    float_data_a: assert property (@(posedge core_clk) disable iff (rst)
        float_seen |=> port_data_bus_oe == '0) else $error("Data driven while floated");
    ext_addr_a: assert property (@(posedge core_clk) disable iff (rst)
        float_n && port_function_select |=> port_address_bus_oe && port_address_bus_out == $past(mem_addr))
        else $error("External address not driven");
    host_addr_off_a: assert property (@(posedge core_clk) disable iff (rst)
        float_n && !port_function_select |=> !port_address_bus_oe) else $error("Address driven in host mode");
    host_addr_cap_a: assert property (@(posedge core_clk) disable iff (rst)
        float_n && !port_function_select |=> host_addr == $past(port_address_bus_in))
        else $error("Host address not captured");
    ext_write_a: assert property (@(posedge core_clk) disable iff (rst)
        float_n && port_function_select && mem_write |=> port_data_bus_oe == '1 && port_data_bus_out == $past(mem_wdata))
        else $error("Write data not driven");
    host_read_a: assert property (@(posedge core_clk) disable iff (rst)
        float_n && !port_function_select && host_read |=> port_data_bus_oe == '1 && port_data_bus_out == $past(host_rdata))
        else $error("Host read data not driven");
    keeper_off_a: assert property (@(posedge core_clk)
        rst ##1 !rst && !drv_next |=> port_data_bus_oe == '0) else $error("Keeper active after reset");
    keeper_hold_a: assert property (@(posedge core_clk) disable iff (rst)
        keeper_en_reg && float_n && !drv_next |=> port_data_bus_oe == '1) else $error("Keeper not holding");
    mode_flags_a: assert property (@(posedge core_clk) disable iff (rst)
        float_n |=> external_memory_mode == $past(port_function_select) && host_port_mode != external_memory_mode)
        else $error("Mode flags wrong");
endmodule : parallel_port_pin_mux
`default_nettype wire

// *** rtl/pin_mux_defs.svh ***
`ifndef PIN_MUX_DEFS_SVH
`define PIN_MUX_DEFS_SVH

`define ADDR_WIDTH 18
`define DATA_WIDTH 16
`define KEEPER_EN_RESET 1'b0
`define MODE_RESET 2'h1

`endif

// *** rtl/pin_mux_pkg.sv ***
package pin_mux_pkg;
    typedef enum logic [1:0] {
        MODE_FLOAT = 2'h1,
        MODE_EXT_MEM = 2'h2
    } port_mode_e;
    typedef enum logic [2:0] {
        ST_FLOAT = 3'h1,
        ST_EXT_MEM = 3'h2,
        ST_HOST = 3'h4
    } mux_state_e;
endpackage : pin_mux_pkg

// *** rtl/data_pin_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface data_pin_if #(parameter int WIDTH = 16);
    logic drive_en;
    logic keeper_en;
    logic [WIDTH-1:0] drive_val;
    logic [WIDTH-1:0] pin_in;
    logic [WIDTH-1:0] keep_val;
    logic [WIDTH-1:0] keep_oe;
    modport ctrl (output drive_en, output keeper_en, output drive_val, output pin_in, input keep_val, input keep_oe);
    modport keeper (input drive_en, input keeper_en, input drive_val, input pin_in, output keep_val, output keep_oe);
endinterface : data_pin_if
`default_nettype wire

// *** rtl/bus_keeper.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_defs.svh"
module bus_keeper #(
    parameter int WIDTH = `DATA_WIDTH
) (
    input wire logic core_clk,
    input wire logic rst,
    data_pin_if.keeper dp
);
    logic [WIDTH-1:0] last_reg;
    logic [WIDTH-1:0] last_next;

    always_comb
    begin
        last_next = last_reg;
        if (dp.drive_en)
        begin
            last_next = dp.drive_val;
        end
        else if (!dp.keeper_en)
        begin
            last_next = dp.pin_in;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            last_reg <= '0;
        end
        else
        begin
            last_reg <= last_next;
        end
    end

    // Per-bit weak hold of last driven level
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_keep
            assign dp.keep_oe[i] = dp.keeper_en & ~dp.drive_en;
            assign dp.keep_val[i] = last_reg[i];
        end
    endgenerate
endmodule : bus_keeper
`default_nettype wire

// *** sim/far_side_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
    input wire logic core_clk,
    input wire logic far_drive,
    input wire logic [17:0] far_addr,
    input wire logic [15:0] far_data,
    input wire logic addr_oe,
    input wire logic [17:0] addr_out,
    input wire logic [15:0] data_oe,
    input wire logic [15:0] data_out,
    output logic [17:0] addr_pin,
    output logic [15:0] data_pin
);
    logic [17:0] addr_last;
    logic [15:0] data_last;
    // Released lines show the inverse of the last level
    always_comb
    begin
        addr_pin = addr_oe ? addr_out : (far_drive ? far_addr : ~addr_last);
        data_pin = far_drive ? far_data : ((data_out & data_oe) | (~data_last & ~data_oe));
    end
    always_ff @(posedge core_clk)
    begin
        addr_last <= addr_pin;
        data_last <= data_pin;
    end
endmodule : far_side_model
`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct packed {logic sel; logic fl; logic wr; logic rd; logic kp; logic aoe; logic [15:0] doe;
        logic ext; logic hst;} row_s;
    localparam row_s ROWS [6] = '{
        '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 16'hFFFF, 1'b1, 1'b0},
        '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0000, 1'b1, 1'b0},
        '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 16'hFFFF, 1'b0, 1'b1},
        '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, 1'b0, 1'b1},
        '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 16'h0000, 1'b0, 1'b0},
        '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 16'h0000, 1'b0, 1'b0}};
    logic core_clk, rst, sel, fl, kp, wr, rd, far_drive, aoe, ext, hst;
    logic [17:0] mem_addr, far_addr, host_addr, aout, apin;
    logic [15:0] mem_wdata, host_rdata, far_data, mem_rdata, host_wdata, dout, doe, dpin;
    int n_fail, checked, cycles;
    parallel_port_pin_mux parallel_port_pin_mux_i (.core_clk(core_clk), .rst(rst), .port_function_select(sel),
        .float_n(fl), .bus_keeper_enable(kp), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_write(wr),
        .mem_rdata(mem_rdata), .host_rdata(host_rdata), .host_read(rd), .host_addr(host_addr),
        .host_wdata(host_wdata), .port_address_bus_in(apin), .port_address_bus_out(aout),
        .port_address_bus_oe(aoe), .port_data_bus_in(dpin), .port_data_bus_out(dout), .port_data_bus_oe(doe),
        .external_memory_mode(ext), .host_port_mode(hst));
    far_side_model far_side_model_i (.core_clk(core_clk), .far_drive(far_drive), .far_addr(far_addr),
        .far_data(far_data), .addr_oe(aoe), .addr_out(aout), .data_oe(doe), .data_out(dout),
        .addr_pin(apin), .data_pin(dpin));
    always #2.5 core_clk = ~core_clk;
    task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic step;
        @(posedge core_clk);
        #1;
    endtask : step
    task automatic conclude;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude
    // Hang guard
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_fail++;
            conclude();
        end
    end
    initial
    begin
        core_clk = 0; rst = 1; sel = 1; fl = 1; kp = 0; wr = 0; rd = 0; far_drive = 0;
        mem_addr = 18'h2A5A5; mem_wdata = 16'hC3A5; host_rdata = 16'h5A3C; far_addr = 18'h1F00F; far_data = 16'hA55A;
        repeat (12) step();
        check("reset addr oe", {17'h0, aoe}, 18'h0);
        check("reset data oe", {2'h0, doe}, 18'h0);
        rst = 0;
        $display("reset test done");
        foreach (ROWS[i])
        begin
            {sel, fl, wr, rd, kp} = {ROWS[i].sel, ROWS[i].fl, ROWS[i].wr, ROWS[i].rd, ROWS[i].kp};
            step();
            check("addr oe", {17'h0, aoe}, {17'h0, ROWS[i].aoe});
            check("data oe", {2'h0, doe}, {2'h0, ROWS[i].doe});
            if (ROWS[i].doe === 16'hFFFF)
                check("data out", {2'h0, dout}, {2'h0, ROWS[i].sel ? mem_wdata : host_rdata});
            if (ROWS[i].aoe)
                check("addr out", aout, mem_addr);
            if (ROWS[i].fl)
                check("mode flags", {16'h0, ext, hst}, {16'h0, ROWS[i].ext, ROWS[i].hst});
            $display("row %0d done", i);
        end
        fl = 1; kp = 0; far_drive = 1; sel = 1; wr = 0;
        for (int i = 0; i < 2; i++)
        begin
            far_data = i ? 16'h0FF0 : 16'h3C96;
            step();
            check("ext read data", {2'h0, mem_rdata}, {2'h0, far_data});
        end
        $display("external read test done");
        sel = 0; rd = 0;
        step();
        check("host release", {17'h0, aoe}, 18'h0);
        for (int i = 0; i < 2; i++)
        begin
            far_addr = i ? 18'h00FF3 : 18'h3C0C3;
            far_data = i ? 16'h9669 : 16'h1E2D;
            step();
            if (i == 1)
                check("host addr oe", {17'h0, aoe}, 18'h0);
            check("host addr", host_addr, far_addr);
            check("host write data", {2'h0, host_wdata}, {2'h0, far_data});
        end
        $display("host write test done");
        far_drive = 0; sel = 1; kp = 1; wr = 1; mem_wdata = 16'h6B1E;
        step();
        wr = 0;
        step();
        check("keeper oe", {2'h0, doe}, 18'h0FFFF);
        check("keeper level", {2'h0, dout}, 18'h06B1E);
        fl = 0;
        step();
        check("float keeper oe", {2'h0, doe}, 18'h0);
        fl = 1;
        $display("keeper test done");
        rst = 1;
        step();
        check("mid reset data oe", {2'h0, doe}, 18'h0);
        rst = 0;
        step();
        check("keeper off after reset", {2'h0, doe}, 18'h0);
        step();
        check("keeper enabled", {2'h0, doe}, 18'h0FFFF);
        $display("mid reset test done");
        conclude();
    end
endmodule : testbench
`default_nettype wire
